/* File: pkg/pps_cfg.svh */
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PPS_FSEL_ADDR   32'hffff0d00
`define PPS_P0DATA_ADDR 32'hffff0d20
`define PPS_P2DATA_ADDR 32'hffff0d40
`define PPS_P2SET_ADDR  32'hffff0d44

// ----------------------------------------
// Function select layout
// ----------------------------------------
`define PPS_FSEL_RESET  32'h11100000
`define PPS_FSEL_WMASK  32'h11111111
`define PPS_FSEL_HVA    24
`define PPS_FSEL_HVB    20
`define PPS_FSEL_STEP   4
`define PPS_PIN_CLK     4

// ----------------------------------------
// Port data layouts
// ----------------------------------------
`define PPS_P2SET_MASK  32'h00630000
`define PPS_SET_P6      22
`define PPS_SET_P5      21
`define PPS_SET_P1      17
`define PPS_SET_P0      16
`define PPS_P2_LVL_LSB  16
`define PPS_P2_OE_LSB   8
`define PPS_P2_IN_LSB   0
`define PPS_P0_LVL_LSB  0
`define PPS_P0_OE_LSB   8
`define PPS_P0_IN_LSB   16

// ----------------------------------------
// Timing
// ----------------------------------------
`define PPS_SYS_KHZ     250000
`define PPS_CLKOUT_KHZ  2560

`endif

/* File: pkg/pps_pkg.sv */
package pps_pkg;
	typedef struct packed {
		logic [4:0] lvl;
		logic [4:0] oe;
	} pps_p0_drive_type;

	typedef struct packed {
		logic [6:0] lvl;
		logic [6:0] oe;
	} pps_p2_drive_type;

	typedef struct packed {
		logic [3:0] lvl;
		logic [3:0] oe;
	} pps_spi_drive_type;

	typedef enum logic {
		PPS_IDLE,
		PPS_ACCESS
	} pps_bus_state_type;
endpackage

/* File: core/pps_port_fn.sv */
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "pps_cfg.svh"

// Notes on behaviour
// - Bit 24 enables high-voltage link line A; set before using it.
// - Bit 20 enables high-voltage link line B; set before using it.
// - Bit 16 set: port 0 pin 4 drives a clock of about 2.604 MHz.
// - Bit 12 set: port 0 pin 3 carries SPI MOSI.
// - Bit 8 set: port 0 pin 2 carries SPI MISO.
// - Bit 4 set: port 0 pin 1 carries SPI clock.
// - Bit 0 set: port 0 pin 0 carries SPI slave select.
// - A cleared select bit leaves the pin as plain GPIO.
// - Set-register bit 22 written one drives port 2 pin 6 high.
// - Set-register bit 21 written one drives port 2 pin 5 high.
// - Set-register bit 17 written one drives port 2 pin 1 high.
// - Set-register bit 16 written one drives port 2 pin 0 high.
// - Zero bits written to the set register leave pins unchanged.
// - Set register touches only pins written one, no read-modify-write.
module pps_port_fn #(
	parameter int ADDR_W = 32
) (
	input  wire logic                       sys_clk,
	input  wire logic                       resetn,
	input  wire logic                       ce,
	input  wire logic [ADDR_W-1:0]          paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic [4:0]                 p0_pin_in,
	output pps_pkg::pps_p0_drive_type       p0_pin,
	input  wire logic [6:0]                 p2_pin_in,
	output pps_pkg::pps_p2_drive_type       p2_pin,
	input  wire pps_pkg::pps_spi_drive_type spi_drive,
	output logic [3:0]                      spi_pin_lvl,
	output logic                            hv_line_a_en,
	output logic                            hv_line_b_en
);
	import pps_pkg::*;

	localparam int HALF_CYC = `PPS_SYS_KHZ / (2 * `PPS_CLKOUT_KHZ);
	localparam int CNT_W = $clog2(HALF_CYC + 1);
	localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
	localparam logic [31:0] P2SET_MASK = `PPS_P2SET_MASK;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [4:0] alt_sel(input logic [31:0] f);
		logic [4:0] s;
		s = '0;
		for (int i = 0; i < 5; i++) begin
			s[i] = f[i * `PPS_FSEL_STEP];
		end
		return s;
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [31:0] r);
		return a == ADDR_W'(r);
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	pps_bus_state_type bus_state_reg;
	logic [31:0]       fsel_reg;
	logic [4:0]        p0_lvl_reg;
	logic [4:0]        p0_oe_reg;
	logic [6:0]        p2_lvl_reg;
	logic [6:0]        p2_oe_reg;
	logic [4:0]        p0_meta_reg;
	logic [4:0]        p0_sync_reg;
	logic [6:0]        p2_meta_reg;
	logic [6:0]        p2_sync_reg;
	logic [CNT_W-1:0]  clk_cnt_reg;
	logic              clk_out_reg;
	logic [31:0]       prdata_next;
	logic              mapped;
	logic              wr_fire;
	logic [6:0]        p2_set_bits;
	logic [4:0]        sel;

	assign mapped = hit(paddr, `PPS_FSEL_ADDR)
		| hit(paddr, `PPS_P0DATA_ADDR)
		| hit(paddr, `PPS_P2DATA_ADDR)
		| hit(paddr, `PPS_P2SET_ADDR);
	assign wr_fire = ce & (bus_state_reg == PPS_ACCESS)
		& psel & penable & pwrite & mapped;
	assign p2_set_bits = pwdata[`PPS_P2_LVL_LSB +: 7]
		& P2SET_MASK[`PPS_P2_LVL_LSB +: 7];
	assign sel = alt_sel(fsel_reg);

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bus_state_reg <= PPS_IDLE;
			pready        <= 1'b0;
			pslverr       <= 1'b0;
			prdata        <= '0;
		end else if (ce) begin
			case (bus_state_reg)
				PPS_IDLE: begin
					if (psel && !penable) begin
						bus_state_reg <= PPS_ACCESS;
						pready        <= 1'b1;
						pslverr       <= !mapped;
						prdata        <= pwrite ? '0 : prdata_next;
					end
				end
				PPS_ACCESS: begin
					bus_state_reg <= PPS_IDLE;
					pready        <= 1'b0;
					pslverr       <= 1'b0;
					prdata        <= '0;
				end
				default: begin
					bus_state_reg <= PPS_IDLE;
					pready        <= 1'b0;
				end
			endcase
		end
	end

	always_comb begin
		prdata_next = '0;
		if (hit(paddr, `PPS_FSEL_ADDR)) begin
			prdata_next = fsel_reg;
		end else if (hit(paddr, `PPS_P0DATA_ADDR)) begin
			prdata_next[`PPS_P0_LVL_LSB +: 5] = p0_lvl_reg;
			prdata_next[`PPS_P0_OE_LSB +: 5]  = p0_oe_reg;
			prdata_next[`PPS_P0_IN_LSB +: 5]  = p0_sync_reg;
		end else if (hit(paddr, `PPS_P2DATA_ADDR)) begin
			prdata_next[`PPS_P2_LVL_LSB +: 7] = p2_lvl_reg;
			prdata_next[`PPS_P2_OE_LSB +: 7]  = p2_oe_reg;
			prdata_next[`PPS_P2_IN_LSB +: 7]  = p2_sync_reg;
		end
		// Set register is write-only and reads as zero
	end

	// ----------------------------------------
	// Function select
	// ----------------------------------------
	// Only select bits, enable bits 24 and 20 and bit 28 hold state; other reserved bits read 0
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fsel_reg <= `PPS_FSEL_RESET;
		end else if (wr_fire && hit(paddr, `PPS_FSEL_ADDR)) begin
			fsel_reg <= pwdata & `PPS_FSEL_WMASK;
		end
	end

	assign hv_line_a_en = fsel_reg[`PPS_FSEL_HVA];
	assign hv_line_b_en = fsel_reg[`PPS_FSEL_HVB];

	// ----------------------------------------
	// Port data registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			p0_lvl_reg <= '0;
			p0_oe_reg  <= '0;
		end else if (wr_fire && hit(paddr, `PPS_P0DATA_ADDR)) begin
			p0_lvl_reg <= pwdata[`PPS_P0_LVL_LSB +: 5];
			p0_oe_reg  <= pwdata[`PPS_P0_OE_LSB +: 5];
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			p2_lvl_reg <= '0;
			p2_oe_reg  <= '0;
		end else if (wr_fire && hit(paddr, `PPS_P2DATA_ADDR)) begin
			p2_lvl_reg <= pwdata[`PPS_P2_LVL_LSB +: 7];
			p2_oe_reg  <= pwdata[`PPS_P2_OE_LSB +: 7];
		end else if (wr_fire && hit(paddr, `PPS_P2SET_ADDR)) begin
			// OR in ones only; zeros keep level
			p2_lvl_reg <= p2_lvl_reg | p2_set_bits;
		end
	end

	// ----------------------------------------
	// Pin input synchronisers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			p0_meta_reg <= '0;
			p0_sync_reg <= '0;
			p2_meta_reg <= '0;
			p2_sync_reg <= '0;
		end else if (ce) begin
			p0_meta_reg <= p0_pin_in;
			p0_sync_reg <= p0_meta_reg;
			p2_meta_reg <= p2_pin_in;
			p2_sync_reg <= p2_meta_reg;
		end
	end

	// ----------------------------------------
	// Clock output divider
	// ----------------------------------------
	// Integer divide gives about 2.604 MHz; exact rate needs a
	// fractional divider, not worth it for a pin clock
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			clk_cnt_reg <= '0;
			clk_out_reg <= 1'b0;
		end else if (ce) begin
			if (!sel[`PPS_PIN_CLK]) begin
				clk_cnt_reg <= '0;
				clk_out_reg <= 1'b0;
			end else if (clk_cnt_reg == HALF_LAST) begin
				clk_cnt_reg <= '0;
				clk_out_reg <= !clk_out_reg;
			end else begin
				clk_cnt_reg <= clk_cnt_reg + CNT_W'(1);
			end
		end
	end

	// ----------------------------------------
	// Pin multiplexers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			p0_pin <= '0;
		end else if (ce) begin
			for (int i = 0; i < 4; i++) begin
				// SPI on pins 0..3
				p0_pin.lvl[i] <= sel[i] ? spi_drive.lvl[i]
					: p0_lvl_reg[i];
				p0_pin.oe[i]  <= sel[i] ? spi_drive.oe[i]
					: p0_oe_reg[i];
			end
			p0_pin.lvl[`PPS_PIN_CLK] <= sel[`PPS_PIN_CLK]
				? clk_out_reg : p0_lvl_reg[`PPS_PIN_CLK];
			p0_pin.oe[`PPS_PIN_CLK]  <= sel[`PPS_PIN_CLK]
				| p0_oe_reg[`PPS_PIN_CLK];
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			p2_pin      <= '0;
			spi_pin_lvl <= '0;
		end else if (ce) begin
			p2_pin.lvl  <= p2_lvl_reg;
			p2_pin.oe   <= p2_oe_reg;
			// SPI sees only pins that are given to it
			spi_pin_lvl <= p0_sync_reg[3:0] & sel[3:0];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence set_write(int b);
		wr_fire && hit(paddr, `PPS_P2SET_ADDR) && pwdata[b];
	endsequence

	hv_line_a_a: assert property (
		wr_fire && hit(paddr, `PPS_FSEL_ADDR)
		|=> hv_line_a_en == $past(pwdata[`PPS_FSEL_HVA]))
		else $error("hv line a enable does not follow write");

	hv_line_b_a: assert property (
		wr_fire && hit(paddr, `PPS_FSEL_ADDR)
		|=> hv_line_b_en == $past(pwdata[`PPS_FSEL_HVB]))
		else $error("hv line b enable does not follow write");

	clock_pin_a: assert property (
		ce && sel[`PPS_PIN_CLK] && $past(ce) && $past(sel[`PPS_PIN_CLK])
		|=> p0_pin.oe[`PPS_PIN_CLK] && p0_pin.lvl[`PPS_PIN_CLK]
			== $past(clk_out_reg))
		else $error("clock pin not driven by divider");

	clock_period_a: assert property (
		sel[`PPS_PIN_CLK] && $changed(clk_out_reg)
		|-> $past(clk_cnt_reg) == HALF_LAST && clk_cnt_reg == '0)
		else $error("clock divider wrap wrong");

	spi_mux_a: assert property (
		ce && sel[3:0] == 4'hf
		|=> p0_pin.lvl[3:0] == $past(spi_drive.lvl)
			&& p0_pin.oe[3:0] == $past(spi_drive.oe))
		else $error("spi pins not routed");

	gpio_mux_a: assert property (
		ce && sel == 5'h00
		|=> p0_pin.lvl == $past(p0_lvl_reg)
			&& p0_pin.oe == $past(p0_oe_reg))
		else $error("gpio pins not routed");

	set_pin6_a: assert property (
		set_write(`PPS_SET_P6) |=> p2_lvl_reg[`PPS_SET_P6 - `PPS_P2_LVL_LSB])
		else $error("port 2 pin 6 not set");

	set_pin5_a: assert property (
		set_write(`PPS_SET_P5) |=> p2_lvl_reg[`PPS_SET_P5 - `PPS_P2_LVL_LSB])
		else $error("port 2 pin 5 not set");

	set_pin1_a: assert property (
		set_write(`PPS_SET_P1) |=> p2_lvl_reg[`PPS_SET_P1 - `PPS_P2_LVL_LSB])
		else $error("port 2 pin 1 not set");

	set_pin0_a: assert property (
		set_write(`PPS_SET_P0) |=> p2_lvl_reg[`PPS_SET_P0 - `PPS_P2_LVL_LSB])
		else $error("port 2 pin 0 not set");

	set_keeps_ones_a: assert property (
		wr_fire && hit(paddr, `PPS_P2SET_ADDR)
		|=> ((p2_lvl_reg ^ $past(p2_lvl_reg)) & ~$past(p2_set_bits)) == '0)
		else $error("set register disturbed other pins");

	set_reads_zero_a: assert property (
		ce && bus_state_reg == PPS_IDLE && psel && !penable
		&& !pwrite && hit(paddr, `PPS_P2SET_ADDR)
		|=> pready && prdata == '0 ##1 $stable(p2_lvl_reg))
		else $error("set register read not zero");

	cov_set_c: cover property (set_write(22) ##1 p2_pin.lvl[6]);
	cov_clock_c: cover property (sel[`PPS_PIN_CLK] && $rose(clk_out_reg));
	cov_spi_c: cover property (ce && sel[3:0] == 4'hf);
	cov_err_c: cover property (pready && pslverr);
endmodule

/* File: tb/pps_pad_model.sv */
`timescale 1ns/1ps
// ----
// Pads seen from outside the port
// ----
module pps_pad_model (
	input  wire logic                      sys_clk,
	input  wire pps_pkg::pps_p0_drive_type p0_pin,
	input  wire pps_pkg::pps_p2_drive_type p2_pin,
	output logic [4:0]                     p0_pin_in,
	output logic [6:0]                     p2_pin_in
);
	import pps_pkg::*;
	logic [11:0] last_reg = '0;
	// Undriven pads have no pull, so show a changing level
	always_ff @(posedge sys_clk) begin
		last_reg <= {p2_pin_in, p0_pin_in};
	end
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			p0_pin_in[i] = p0_pin.oe[i] ? p0_pin.lvl[i] : ~last_reg[i];
		end
		for (int i = 0; i < 7; i++) begin
			p2_pin_in[i] = p2_pin.oe[i] ? p2_pin.lvl[i] : ~last_reg[i+5];
		end
	end
endmodule

/* File: tb/pps_port_fn_test.sv */
`timescale 1ns/1ps
module pps_port_fn_test;
	import pps_pkg::*;
	logic              sys_clk = 0;
	logic              resetn = 0;
	logic              ce = 1;
	logic              psel = 0;
	logic              penable = 0;
	logic              pwrite = 0;
	logic [31:0]       paddr = '0;
	logic [31:0]       pwdata = '0;
	logic [31:0]       prdata, rd;
	logic              pready, pslverr, er, hva, hvb;
	logic [4:0]        p0_in;
	logic [6:0]        p2_in;
	logic [3:0]        spi_lvl;
	pps_p0_drive_type  p0_pin;
	pps_p2_drive_type  p2_pin;
	pps_spi_drive_type spi_drive = '0;
	int                miscompares = 0;
	int                total_checks = 0;
	int                cycles = 0;
	int                n;
	logic              v;
	logic [6:0]        exp2;
	int                sb[4] = '{22, 21, 17, 16};
	int                pb[4] = '{6, 5, 1, 0};

	pps_port_fn dut_u (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .p0_pin_in(p0_in), .p0_pin(p0_pin),
		.p2_pin_in(p2_in), .p2_pin(p2_pin), .spi_drive(spi_drive),
		.spi_pin_lvl(spi_lvl), .hv_line_a_en(hva), .hv_line_b_en(hvb));
	pps_pad_model pad_u (.sys_clk(sys_clk), .p0_pin(p0_pin),
		.p2_pin(p2_pin), .p0_pin_in(p0_in), .p2_pin_in(p2_in));

	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	// ----
	// Tasks
	// ----
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Called just after a rising edge; leaves one idle cycle after
	task automatic apb(logic [31:0] a, logic w, logic [31:0] d);
		n = 0;
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		chk("pready wait", 1, n < 20);
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
	endtask
	task automatic settle();
		repeat (2) @(posedge sys_clk);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		apb(32'hffff0d00, 0, 0);
		chk("fsel reset", 32'h11100000, rd);
		chk("hv reset", 2'b11, {hva, hvb});
		chk("p0 oe reset", 0, p0_pin.oe);
		apb(32'hffff0d00, 1, 32'h11111111);
		apb(32'hffff0d00, 0, 0);
		chk("fsel mask", 32'h11111111, rd);
		for (int i = 0; i < 4; i++) begin
			apb(32'hffff0d00, 1, 32'h10000000 | (i[1] << 24) | (i[0] << 20));
			chk("hv enables", i[1:0], {hva, hvb});
		end
		apb(32'hffff0d04, 0, 0);
		chk("unmapped err", 1, er);
		chk("unmapped data", 0, rd);
		$display("test regs done");
	endtask
	task automatic t_spi();
		spi_drive <= '{lvl: 4'ha, oe: 4'hf};
		apb(32'hffff0d00, 1, 32'h10001111);
		settle();
		chk("spi lvl", 4'ha, p0_pin.lvl[3:0]);
		chk("spi oe", 4'hf, p0_pin.oe[3:0]);
		spi_drive <= '{lvl: 4'h5, oe: 4'hf};
		repeat (5) @(posedge sys_clk);
		chk("spi in", 4'h5, spi_lvl);
		apb(32'hffff0d20, 1, 32'h00001f03);
		apb(32'hffff0d00, 1, 32'h10000000);
		repeat (4) @(posedge sys_clk);
		chk("gpio lvl", 5'h03, p0_pin.lvl);
		chk("gpio oe", 5'h1f, p0_pin.oe);
		chk("spi masked", 0, spi_lvl);
		$display("test spi done");
	endtask
	task automatic t_clk();
		apb(32'hffff0d00, 1, 32'h10010000);
		settle();
		chk("clk oe", 1, p0_pin.oe[4]);
		for (int k = 0; k < 2; k++) begin
			v = p0_pin.lvl[4];
			n = 0;
			while (p0_pin.lvl[4] === v && n < 200) begin
				@(posedge sys_clk);
				n++;
			end
		end
		chk("clk half period", 48, n);
		// Longer than one half period, shorter than two
		ce <= 0;
		repeat (2) @(posedge sys_clk);
		v = p0_pin.lvl[4];
		repeat (60) @(posedge sys_clk);
		chk("ce freeze", v, p0_pin.lvl[4]);
		ce <= 1;
		apb(32'hffff0d00, 1, 32'h10000000);
		settle();
		chk("clk off", 0, p0_pin.lvl[4]);
		$display("test clock done");
	endtask
	task automatic t_set();
		apb(32'hffff0d40, 1, 32'h00007f00);
		exp2 = '0;
		for (int i = 0; i < 4; i++) begin
			apb(32'hffff0d44, 1, 32'h1 << sb[i]);
			exp2[pb[i]] = 1'b1;
			settle();
			chk("p2 set", exp2, p2_pin.lvl);
		end
		apb(32'hffff0d40, 1, 32'h00047f00);
		apb(32'hffff0d44, 1, 32'h00010000);
		apb(32'hffff0d44, 1, 32'h0);
		settle();
		chk("p2 keep", 7'h05, p2_pin.lvl);
		apb(32'hffff0d44, 0, 0);
		chk("set read", 0, rd);
		settle();
		chk("read no effect", 7'h05, p2_pin.lvl);
		$display("test set done");
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		resetn <= 1;
		@(posedge sys_clk);
		t_regs();
		t_spi();
		t_clk();
		t_set();
		summarize();
	end
endmodule
